// ===== rtl/esr_pkg.sv
package esr_pkg;
  // array geometry
  localparam int ESR_ADDR_W = 8;
  localparam int ESR_DEPTH = 256;
  localparam int ESR_SYNC_STAGES = 2;
  // control byte layout
  localparam logic [3:0] ESR_DEV_CODE = 4'ha;
  localparam int ESR_CODE_MSB = 7;
  localparam int ESR_CODE_LSB = 4;
  localparam int ESR_CS_MSB = 3;
  localparam int ESR_CS_LSB = 1;
  localparam int ESR_RW_BIT = 0;
  localparam logic ESR_RW_READ = 1'b1;
  // bit counting and pointer step
  localparam logic [3:0] ESR_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ESR_CNT_ONE = 4'h1;
  localparam logic [3:0] ESR_CNT_ZERO = 4'h0;
  localparam logic [7:0] ESR_PTR_STEP = 8'h01;
  localparam logic [7:0] ESR_PTR_RESET = 8'h00;
  localparam logic [7:0] ESR_BYTE_ZERO = 8'h00;

  // raw pin levels that travel together through the synchroniser
  typedef struct packed {
    logic scl;
    logic sda;
    logic [2:0] cs;
  } esr_pins_t;

  // bus idle: both lines high, selects low
  localparam esr_pins_t ESR_PINS_IDLE = 5'h18;

  typedef enum logic [2:0] {
    ESR_IDLE = 3'b000,
    ESR_CTRL = 3'b001,
    ESR_CTRL_ACK = 3'b010,
    ESR_ADDR = 3'b011,
    ESR_ADDR_ACK = 3'b100,
    ESR_TX = 3'b101,
    ESR_TX_ACK = 3'b110,
    ESR_IGNORE = 3'b111
  } esr_state_t;
endpackage

// ===== rtl/esr_pin_sync.sv
module esr_pin_sync #(
  parameter int STAGES = 2
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire esr_pkg::esr_pins_t pins_in,
  output esr_pkg::esr_pins_t pins_out
);
  import esr_pkg::*;

  esr_pins_t stage [STAGES];

  // chain of flops; only the last stage is seen outside
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= ESR_PINS_IDLE;
      end
    end else begin
      stage[0] <= pins_in;
      for (int i = 1; i < STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign pins_out = stage[STAGES-1];
endmodule

// ===== rtl/esr_read_engine.sv
module esr_read_engine #(
  parameter int ADDR_W = esr_pkg::ESR_ADDR_W,
  parameter int DEPTH = esr_pkg::ESR_DEPTH
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic chip_select_pin_0,
  input wire logic chip_select_pin_1,
  input wire logic chip_select_pin_2,
  input wire logic prog_busy_in,
  input wire logic load_en_in,
  input wire logic [ADDR_W-1:0] load_addr_in,
  input wire logic [7:0] load_data_in,
  output logic [ADDR_W-1:0] pointer_out,
  output esr_pkg::esr_state_t state_out
);
  import esr_pkg::*;

  esr_pins_t pins_raw;
  esr_pins_t pins;
  logic scl_d;
  logic sda_d;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] mem [DEPTH];
  esr_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [ADDR_W-1:0] ptr;
  logic is_read;
  logic master_ack;
  logic sel_match;
  logic byte_done;

  assign pins_raw = '{scl: scl_in, sda: sda_in,
                      cs: {chip_select_pin_2, chip_select_pin_1,
                           chip_select_pin_0}};

  // pins pass two flops before anything looks at them
  esr_pin_sync #(
    .STAGES(ESR_SYNC_STAGES)
  ) u_sync (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .pins_in(pins_raw),
    .pins_out(pins)
  );

  // previous synchronised levels for edge detection
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_d <= ESR_PINS_IDLE.scl;
      sda_d <= ESR_PINS_IDLE.sda;
    end else begin
      scl_d <= pins.scl;
      sda_d <= pins.sda;
    end
  end

  // bus conditions: data moving while clock stays high
  assign start_seen = pins.scl && scl_d && sda_d && !pins.sda;
  assign stop_seen = pins.scl && scl_d && !sda_d && pins.sda;
  assign scl_rise = pins.scl && !scl_d;
  assign scl_fall = !pins.scl && scl_d;
  assign byte_done = (bit_cnt == ESR_BITS_PER_BYTE);

  // control byte match on code and strapped selects
  assign sel_match =
    (rx_shift[ESR_CODE_MSB:ESR_CODE_LSB] == ESR_DEV_CODE) &&
    (rx_shift[ESR_CS_MSB:ESR_CS_LSB] == pins.cs);

  // byte store, filled from the user side
  always_ff @(posedge clock_in) begin
    if (load_en_in) begin
      mem[load_addr_in] <= load_data_in;
    end
  end

  // serial receive shifter and bit counter
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_shift <= ESR_BYTE_ZERO;
      bit_cnt <= ESR_CNT_ZERO;
      master_ack <= 1'b0;
    end else if (start_seen || stop_seen) begin
      bit_cnt <= ESR_CNT_ZERO;
    end else if (scl_rise) begin
      if (state == ESR_TX_ACK) begin
        master_ack <= !pins.sda;
      end else begin
        rx_shift <= {rx_shift[6:0], pins.sda};
        bit_cnt <= bit_cnt + ESR_CNT_ONE;
      end
    end else if (scl_fall && byte_done) begin
      bit_cnt <= ESR_CNT_ZERO;
    end else if (scl_fall && (state == ESR_CTRL_ACK ||
                              state == ESR_TX_ACK)) begin
      bit_cnt <= ESR_CNT_ZERO;
    end
  end

  // transfer sequencing
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ESR_IDLE;
      is_read <= 1'b0;
    end else if (stop_seen) begin
      state <= ESR_IDLE;
    end else if (start_seen) begin
      state <= ESR_CTRL;
    end else if (scl_fall) begin
      case (state)
        ESR_IDLE: begin
          state <= ESR_IDLE;
        end
        ESR_CTRL: begin
          if (byte_done) begin
            is_read <= (rx_shift[ESR_RW_BIT] == ESR_RW_READ);
            if (sel_match && !prog_busy_in) begin
              state <= ESR_CTRL_ACK;
            end else begin
              state <= ESR_IGNORE;
            end
          end
        end
        ESR_CTRL_ACK: begin
          state <= is_read ? ESR_TX : ESR_ADDR;
        end
        ESR_ADDR: begin
          if (byte_done) begin
            state <= prog_busy_in ? ESR_IGNORE : ESR_ADDR_ACK;
          end
        end
        ESR_ADDR_ACK: begin
          state <= ESR_IGNORE;
        end
        ESR_TX: begin
          if (byte_done) begin
            state <= ESR_TX_ACK;
          end
        end
        ESR_TX_ACK: begin
          state <= master_ack ? ESR_TX : ESR_IGNORE;
        end
        default: begin
          state <= ESR_IGNORE;
        end
      endcase
    end
  end

  // address pointer: loaded by word address, stepped per byte sent
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ptr <= ESR_PTR_RESET;
    end else if (scl_fall && !start_seen && !stop_seen) begin
      if (state == ESR_ADDR && byte_done && !prog_busy_in) begin
        ptr <= rx_shift[ADDR_W-1:0];
      end else if ((state == ESR_CTRL_ACK && is_read) ||
                   (state == ESR_TX_ACK && master_ack)) begin
        ptr <= ptr + ESR_PTR_STEP[ADDR_W-1:0];
      end
    end
  end

  // transmit shifter: byte fetched as it starts going out
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_shift <= ESR_BYTE_ZERO;
    end else if (scl_fall && !start_seen && !stop_seen) begin
      if ((state == ESR_CTRL_ACK && is_read) ||
          (state == ESR_TX_ACK && master_ack)) begin
        tx_shift <= mem[ptr];
      end else if (state == ESR_TX) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // data line drive: low for acknowledge or a zero data bit
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_oe_out <= 1'b0;
    end else if (start_seen || stop_seen) begin
      sda_oe_out <= 1'b0;
    end else if (scl_fall) begin
      case (state)
        ESR_CTRL: begin
          sda_oe_out <= byte_done && sel_match && !prog_busy_in;
        end
        ESR_ADDR: begin
          sda_oe_out <= byte_done && !prog_busy_in;
        end
        ESR_CTRL_ACK: begin
          sda_oe_out <= is_read && !mem[ptr][7];
        end
        ESR_TX: begin
          sda_oe_out <= !byte_done && !tx_shift[6];
        end
        ESR_TX_ACK: begin
          sda_oe_out <= master_ack && !mem[ptr][7];
        end
        default: begin
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // open-drain level and observation outputs
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_out <= 1'b0;
      pointer_out <= ESR_PTR_RESET;
      state_out <= ESR_IDLE;
    end else begin
      sda_out <= 1'b0;
      pointer_out <= ptr;
      state_out <= state;
    end
  end
endmodule

// ===== dv/esr_read_asserts.sv
// watches the bus side of the read engine
module esr_read_asserts
  import esr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic prog_busy_in,
  input wire logic [7:0] pointer_out,
  input wire esr_state_t state_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // open drain: only ever pulls low
  chk_drive_low: assert property (sda_out == 1'b0)
    else $error("data drive level not low");
  chk_idle_free: assert property (state_out == ESR_IDLE |-> !sda_oe_out)
    else $error("line driven while idle");
  chk_ignore_free: assert property (
    state_out == ESR_IGNORE |-> !sda_oe_out)
    else $error("line driven while ignoring");
  chk_ctrl_ack: assert property (
    state_out == ESR_CTRL_ACK && scl_in |-> sda_oe_out)
    else $error("control byte not acknowledged");
  chk_addr_ack: assert property (
    state_out == ESR_ADDR_ACK && scl_in && !prog_busy_in |-> sda_oe_out)
    else $error("word address not acknowledged");
  chk_txack_free: assert property (
    state_out == ESR_TX_ACK && scl_in |-> !sda_oe_out)
    else $error("line held in master ack slot");
  // output moves 3 to 6 clocks after a clock fall, never while high
  chk_ans_delay: assert property ($changed(sda_oe_out) |->
    !scl_in && $past(scl_in, 6) && !$past(scl_in, 3))
    else $error("data change outside low phase");
  chk_busy_mute: assert property ($rose(sda_oe_out) && state_out inside
    {ESR_CTRL, ESR_CTRL_ACK, ESR_ADDR, ESR_ADDR_ACK} |-> !($past(prog_busy_in)
    && $past(prog_busy_in, 2) && $past(prog_busy_in, 3)))
    else $error("acknowledge given while busy");
  chk_ptr_step: assert property ($changed(pointer_out) &&
    state_out inside {ESR_CTRL_ACK, ESR_TX, ESR_TX_ACK} |->
    pointer_out == $past(pointer_out) + 8'h01)
    else $error("pointer step not one");
  chk_ptr_hold: assert property (
    state_out inside {ESR_IDLE, ESR_IGNORE} &&
    $past(state_out) inside {ESR_IDLE, ESR_IGNORE} |-> $stable(pointer_out))
    else $error("pointer moved while idle");
  cov_wrap: cover property (pointer_out == 8'h00 && $past(pointer_out) == 8'hff);
  cov_ignore: cover property (state_out == ESR_IGNORE);
  cov_addr_ack: cover property (state_out == ESR_ADDR_ACK && sda_oe_out);
endmodule

bind esr_read_engine esr_read_asserts u_chk (.clock_in, .rstn_in, .scl_in,
  .sda_out, .sda_oe_out, .prog_busy_in, .pointer_out, .state_out);

// ===== dv/esr_bus_master.sv
// two-wire bus master; releases its data line high when not driving low
module esr_bus_master (
  input wire logic clock_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // start (lvl 0) or stop (lvl 1): data moves while clock is high
  task automatic cond(input logic lvl);
    sda_out <= !lvl;
    tick(5);
    scl_out <= 1'b1;
    tick(10);
    sda_out <= lvl;
    tick(10);
    scl_out <= lvl;
    tick(5);
  endtask
  // one bit: set in low phase, sample at end of high phase
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    tick(5);
    scl_out <= 1'b1;
    tick(10);
    r = sda_in;
    scl_out <= 1'b0;
    tick(5);
  endtask
  // byte msb first, then the ninth acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic a_in,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a_in, a);
  endtask
endmodule

// ===== dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import esr_pkg::*;
  localparam logic [7:0] CW = {ESR_DEV_CODE, 3'h6, 1'b0};
  localparam logic [7:0] CR = {ESR_DEV_CODE, 3'h6, 1'b1};
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic busy = 1'b0;
  logic load_en = 1'b0;
  logic [7:0] load_addr = 8'h00;
  logic [7:0] load_data = 8'h00;
  logic [2:0] cs_pins = 3'h6;
  logic scl, m_sda, d_sda, d_oe, sda, a;
  logic [7:0] ptr, q;
  esr_state_t st;
  int err_total = 0;
  int comparisons = 0;
  // wired-and bus line with pull-up
  assign sda = m_sda & !d_oe;
  always #2.5 clock_in = !clock_in;
  esr_read_engine uut (.clock_in(clock_in), .rstn_in(rstn_in),
    .scl_in(scl), .sda_in(sda), .sda_out(d_sda), .sda_oe_out(d_oe),
    .chip_select_pin_0(cs_pins[0]), .chip_select_pin_1(cs_pins[1]),
    .chip_select_pin_2(cs_pins[2]), .prog_busy_in(busy),
    .load_en_in(load_en), .load_addr_in(load_addr),
    .load_data_in(load_data), .pointer_out(ptr), .state_out(st));
  esr_bus_master mst (.clock_in(clock_in), .sda_in(sda), .scl_out(scl),
    .sda_out(m_sda));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // send a byte and compare the device acknowledge
  task automatic wr(input logic [7:0] d, input logic ack);
    mst.xfer(d, 1'b1, q, a);
    check({7'h00, a}, {7'h00, !ack});
  endtask
  // read n bytes from p, acking all but the last
  task automatic rd(input logic [7:0] p, input int n);
    for (int i = 0; i < n; i++) begin
      mst.xfer(8'hff, i == n - 1, q, a);
      check(q, (p + i[7:0]) ^ 8'h5c);
    end
  endtask
  // random read at the top, streaming across the wrap, then current read
  task automatic random_seq;
    mst.cond(1'b0);
    wr(CW, 1'b1);
    wr(8'hfe, 1'b1);
    mst.cond(1'b0);
    wr(CR, 1'b1);
    rd(8'hfe, 3);
    mst.cond(1'b1);
    check(ptr, 8'h01);
    mst.cond(1'b0);
    wr(CR, 1'b1);
    rd(8'h01, 1);
    mst.cond(1'b1);
    check(ptr, 8'h02);
    check({7'h00, sda}, 8'h01);
    check({7'h00, d_sda}, 8'h00);
    check({5'h00, st}, {5'h00, ESR_IDLE});
  endtask
  // wrong code, wrong selects, busy: no ack, pointer kept
  task automatic refusals;
    logic [7:0] bad [3];
    bad = '{{4'h5, 3'h6, 1'b1}, {ESR_DEV_CODE, 3'h2, 1'b1}, CR};
    for (int k = 0; k < 3; k++) begin
      busy <= (k == 2);
      mst.cond(1'b0);
      wr(bad[k], 1'b0);
      check({5'h00, st}, {5'h00, ESR_IGNORE});
      mst.cond(1'b1);
      check(ptr, 8'h02);
    end
    // busy at the word address: no acknowledge, pointer not loaded
    busy <= 1'b0;
    mst.cond(1'b0);
    wr(CW, 1'b1);
    busy <= 1'b1;
    wr(8'h40, 1'b0);
    busy <= 1'b0;
    mst.cond(1'b1);
    check(ptr, 8'h02);
    // new strapped selects: old selects refused, matching ones served
    cs_pins <= 3'h1;
    mst.cond(1'b0);
    wr(CR, 1'b0);
    check({5'h00, st}, {5'h00, ESR_IGNORE});
    mst.cond(1'b1);
    mst.cond(1'b0);
    wr({ESR_DEV_CODE, 3'h1, 1'b1}, 1'b1);
    rd(8'h02, 1);
    mst.cond(1'b1);
    check(ptr, 8'h03);
  endtask
  // reset in mid-run: pointer back to its reset value, array kept
  task automatic mid_reset;
    rstn_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    check(ptr, 8'h00);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    mst.cond(1'b0);
    wr({ESR_DEV_CODE, 3'h1, 1'b1}, 1'b1);
    rd(8'h00, 1);
    mst.cond(1'b1);
    check(ptr, 8'h01);
  endtask
  // hang guard
  initial begin
    repeat (90000) @(posedge clock_in);
    err_total++;
    report_and_stop;
  end
  // reset, fill the array with a known pattern, run scenarios
  initial begin
    repeat (4) @(posedge clock_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(posedge clock_in);
      load_en <= 1'b1;
      load_addr <= i[7:0];
      load_data <= i[7:0] ^ 8'h5c;
    end
    @(posedge clock_in);
    load_en <= 1'b0;
    repeat (4) @(posedge clock_in);
    random_seq;
    refusals;
    mid_reset;
    report_and_stop;
  end
endmodule
